//--- include/tbc_pkg.sv
`default_nettype none
package tbc_pkg;
   // Register byte addresses: printed offsets are not all multiples of four, so index * 4
   localparam logic [7:0] IDX_TENBASE = 8'h1A;
   localparam logic [7:0] IDX_SELFTEST_ERR_GAP = 8'h1B;
   localparam logic [7:0] IDX_SELFTEST_LEN = 8'h1C;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
   localparam logic [7:0] IDX_PHY_STATUS = 8'h10;
   localparam int ADDR_W = 12;
   // Tenbase control field positions
   localparam int TB_THRESH_BIT = 13;
   localparam int TB_SQ_LSB = 9;
   localparam int TB_SQ_W = 4;
   localparam int TB_NLP_BIT = 7;
   localparam int TB_POL_BIT = 4;
   localparam int TB_JAB_BIT = 0;
   localparam int PS_POL_BIT = 12;
   localparam logic [3:0] SQ_MAX = 4'h8;
   // Self-test fields
   localparam int ERR_LSB = 8;
   localparam int ERR_LOCK_BIT = 15;
   localparam logic [7:0] ERR_SAT = 8'hFF;
   localparam logic [7:0] GAP_RESET = 8'h7D;
   localparam logic [10:0] LEN_RESET = 11'h5EE;
   localparam int GAP_MULT = 4;
   // Interrupt status bits
   localparam int IRQ_POL = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_W = 2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tbc_pkg
`default_nettype wire

//--- logic/tbc_regs.sv
// Summary of operation
// - Bit 13 set applies lowered receive threshold for longer cables.
// - Squelch field bits 12-9, 200mV plus 50mV per code, max code 0x8.
// - Bit 7 clear sends link pulses; set suppresses them.
// - Bit 4 shows receive polarity, always equal to status copy bit 12.
// - Reading tenbase register clears both polarity copies; status read clears neither.
// - Bit 0 set disables jabber, only effective in 10BASE-Te mode.
// - Bits 15-8 of first self-test register count errored PRBS bytes.
// - Writing 1 to bit 15 captures count and clears running counter.
// - With counter mode 0 the errored-byte counter saturates at 0xFF.
// - Generator gap in bytes is bits 7-0 times four, reset 0x7D.
// - Generator frame length is bits 10-0 of second register, reset 0x5EE.
`default_nettype none
module tbc_regs
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [tbc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tbc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_polarity_inverted,
   input wire logic prbs_byte_error,
   input wire logic error_counter_mode,
   output logic lower_rx_threshold,
   output logic [3:0] squelch_level,
   output logic link_pulse_tx_off,
   output logic jabber_off,
   output logic [7:0] generator_gap_quads,
   output logic [9:0] generator_gap_bytes,
   output logic [10:0] generator_frame_bytes,
   output logic phy_status_polarity,
   output logic irq
);

   // All state lives in one packed struct so that reset, hold and update
   // are each written once. The bus slots hold one address and one data
   // beat; a second beat waits on ready rather than being queued, which
   // keeps the slave small at the cost of one idle cycle between writes.
   // The polarity chain is the only part fed from outside the clock domain.
   typedef struct packed {
      logic pol_s1;
      logic pol_s2;
      logic pol_prev;
      logic polarity;
      logic thresh;
      logic [3:0] squelch;
      logic nlp_off;
      logic jab_off;
      logic [7:0] err_run;
      logic [7:0] err_held;
      logic [7:0] gap;
      logic [10:0] len;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic aw_hold;
      logic [tbc_pkg::ADDR_W-1:0] aw_addr;
      logic w_hold;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tbc_state_t;

   tbc_state_t st;
   tbc_state_t next_st;

   // Word index of a byte address; unaligned or out-of-window addresses never match
   // Upper address bits are checked so that no register shows up at an alias
   // Index 0xFF is left unmapped on purpose and serves as the miss code
   function automatic logic [7:0] tbc_index(input logic [tbc_pkg::ADDR_W-1:0] a);
      logic ok;
      ok = (a[1:0] == 2'h0) && (a[tbc_pkg::ADDR_W-1:10] == 2'h0);
      tbc_index = ok ? a[9:2] : 8'hFF;
   endfunction : tbc_index

   // Mapped test shared by both channels, so read and write agree on the map

   function automatic logic tbc_mapped(input logic [7:0] i);
      tbc_mapped = (i == tbc_pkg::IDX_TENBASE) || (i == tbc_pkg::IDX_SELFTEST_ERR_GAP) ||
         (i == tbc_pkg::IDX_SELFTEST_LEN) || (i == tbc_pkg::IDX_IRQ_STATUS) ||
         (i == tbc_pkg::IDX_IRQ_MASK) || (i == tbc_pkg::IDX_PHY_STATUS);
   endfunction : tbc_mapped

   logic [7:0] widx;
   logic [7:0] ridx;
   logic do_write;
   logic do_read;
   logic [15:0] tb_word;
   logic [15:0] wd;
   logic [15:0] wmask;

   // Decode, and tenbase read image built from live state
   // A write fires only once both beats are held and the last response is gone;
   // a read fires as soon as the read slot is free, one address per answer.
   // Strobes are widened to a bit mask so each field obeys the lane that holds it.
   always_comb
   begin
      widx = tbc_index(st.aw_addr);
      ridx = tbc_index(s_axi_araddr);
      do_write = st.aw_hold && st.w_hold && !st.bvalid;
      do_read = s_axi_arvalid && !st.rvalid;
      wd = st.w_data[15:0];
      wmask = {{8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
      tb_word = 16'h0000;
      tb_word[tbc_pkg::TB_THRESH_BIT] = st.thresh;
      tb_word[tbc_pkg::TB_SQ_LSB +: tbc_pkg::TB_SQ_W] = st.squelch;
      tb_word[tbc_pkg::TB_NLP_BIT] = st.nlp_off;
      tb_word[tbc_pkg::TB_POL_BIT] = st.polarity;
      tb_word[tbc_pkg::TB_JAB_BIT] = st.jab_off;
   end

   // Next-state logic for bus slave, fields and event counters
   // Order matters here: later assignments win, so event sets are placed after
   // the software clears they compete with. That keeps a flag from being lost
   // when an event lands in the very cycle that software clears it.
   // The counter and interrupt flags are written in more than one branch below;
   // every branch starts from the copy of the current state.
   always_comb
   begin
      next_st = st;
      // Polarity pin crosses in through two flops before use
      next_st.pol_s1 = rx_polarity_inverted;
      next_st.pol_s2 = st.pol_s1;
      next_st.pol_prev = st.pol_s2;
      // Write channel capture, either order
      if (s_axi_awvalid && !st.aw_hold)
      begin
         next_st.aw_hold = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_hold)
      begin
         next_st.w_hold = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
      // Errored-byte counter; saturates in mode 0, wraps otherwise
      if (prbs_byte_error)
      begin
         if (error_counter_mode || st.err_run != tbc_pkg::ERR_SAT)
         begin
            next_st.err_run = st.err_run + 8'h01;
         end
         next_st.irq_status[tbc_pkg::IRQ_ERR] = 1'b1;
      end
      // Register write: only defined fields take data, others ignored
      // Unmapped writes answer with an error and change nothing, so a stray
      // address from software cannot disturb the receiver configuration.
      // The capture bit is an action, not a field: it is never stored.
      if (do_write)
      begin
         next_st.aw_hold = 1'b0;
         next_st.w_hold = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = tbc_mapped(widx) ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
         unique case (widx)
            tbc_pkg::IDX_TENBASE:
            begin
               if (wmask[tbc_pkg::TB_THRESH_BIT])
               begin
                  next_st.thresh = wd[tbc_pkg::TB_THRESH_BIT];
                  next_st.squelch = wd[tbc_pkg::TB_SQ_LSB +: tbc_pkg::TB_SQ_W];
               end
               if (wmask[tbc_pkg::TB_NLP_BIT])
               begin
                  next_st.nlp_off = wd[tbc_pkg::TB_NLP_BIT];
                  next_st.jab_off = wd[tbc_pkg::TB_JAB_BIT];
               end
            end
            tbc_pkg::IDX_SELFTEST_ERR_GAP:
            begin
               if (wmask[tbc_pkg::ERR_LOCK_BIT] && wd[tbc_pkg::ERR_LOCK_BIT])
               begin
                  // Capture and restart; an error in this cycle is counted afresh
                  next_st.err_held = st.err_run;
                  next_st.err_run = prbs_byte_error ? 8'h01 : 8'h00;
               end
               if (wmask[0])
               begin
                  next_st.gap = wd[7:0];
               end
            end
            tbc_pkg::IDX_SELFTEST_LEN:
            begin
               next_st.len = (wd[10:0] & wmask[10:0]) | (st.len & ~wmask[10:0]);
            end
            tbc_pkg::IDX_IRQ_STATUS:
            begin
               next_st.irq_status = st.irq_status & ~(wd[1:0] & wmask[1:0]);
            end
            tbc_pkg::IDX_IRQ_MASK:
            begin
               next_st.irq_mask = (wd[1:0] & wmask[1:0]) | (st.irq_mask & ~wmask[1:0]);
            end
            default:
            begin
            end
         endcase
         // Error event in the clear cycle keeps its flag
         if (prbs_byte_error)
         begin
            next_st.irq_status[tbc_pkg::IRQ_ERR] = 1'b1;
         end
      end
      // Register read, one cycle after arvalid
      // Data is registered so the answer stands unchanged until rready, even
      // if the fields move meanwhile. Reading the tenbase word is the only read
      // with a side effect, clearing the shared polarity flag.
      // Unmapped reads return zero with an error response.
      if (do_read)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = 32'h0000_0000;
         next_st.rresp = tbc_mapped(ridx) ? tbc_pkg::RESP_OKAY : tbc_pkg::RESP_SLVERR;
         unique case (ridx)
            tbc_pkg::IDX_TENBASE:
            begin
               next_st.rdata[15:0] = tb_word;
               next_st.polarity = 1'b0;
            end
            tbc_pkg::IDX_SELFTEST_ERR_GAP:
            begin
               next_st.rdata[15:0] = {st.err_held, st.gap};
            end
            tbc_pkg::IDX_SELFTEST_LEN:
            begin
               next_st.rdata[10:0] = st.len;
            end
            tbc_pkg::IDX_IRQ_STATUS:
            begin
               next_st.rdata[1:0] = st.irq_status;
            end
            tbc_pkg::IDX_IRQ_MASK:
            begin
               next_st.rdata[1:0] = st.irq_mask;
            end
            tbc_pkg::IDX_PHY_STATUS:
            begin
               // Status copy read leaves the flag alone
               next_st.rdata[tbc_pkg::PS_POL_BIT] = st.polarity;
            end
            default:
            begin
            end
         endcase
      end
      // Inverted polarity detection sets the flag; detection beats the read clear
      // While the pin stays high the flag simply reasserts, so software sees it
      // again on the next read; the interrupt only marks the rising edge.
      if (st.pol_s2)
      begin
         next_st.polarity = 1'b1;
      end
      if (st.pol_s2 && !st.pol_prev)
      begin
         next_st.irq_status[tbc_pkg::IRQ_POL] = 1'b1;
      end
   end

   // State register with synchronous reset
   // Reset loads constants only; the two non-zero fields are the generator
   // defaults, everything else including the sync chain starts at zero.
   // The chain's zero matches the pin's idle level, so no false edge follows.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.gap <= tbc_pkg::GAP_RESET;
         st.len <= tbc_pkg::LEN_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Handshakes: ready while the holding slot is free
   // Readies are combinational from state only, never from a valid input,
   // so no path runs from master valid back to master ready in one cycle.
   // Responses come straight from flops and stand until taken.
   assign s_axi_awready = !st.aw_hold;
   assign s_axi_wready = !st.w_hold;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // Field outputs straight from flops
   // The gap in bytes is only a wiring shift of the field, no extra register.
   // Squelch codes above the top documented code are stored as written;
   // the receiver must treat them as its highest setting.
   assign lower_rx_threshold = st.thresh;
   assign squelch_level = st.squelch;
   assign link_pulse_tx_off = st.nlp_off;
   assign jabber_off = st.jab_off;
   assign generator_gap_quads = st.gap;
   assign generator_gap_bytes = {st.gap, 2'b00};
   assign generator_frame_bytes = st.len;
   assign phy_status_polarity = st.polarity;
   // Level interrupt, high while any unmasked status bit is set
   // Masking hides a flag from the pin but does not stop it being recorded
   assign irq = |(st.irq_status & st.irq_mask);

endmodule : tbc_regs
`default_nettype wire

//--- tb/tbc_phy_model.sv
`default_nettype none
module tbc_phy_model (
   input wire logic aclk,
   output logic rx_polarity_inverted,
   output logic prbs_byte_error
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      rx_polarity_inverted = 1'b0;
      prbs_byte_error = 1'b0;
   end
   // Receiver polarity level, moved right after an edge
   task pol(input logic x);
      @(posedge aclk);
      rx_polarity_inverted <= x;
   endtask : pol
   // Back-to-back errored bytes stress the counter hardest
   task errs(input int n);
      repeat (n) @(posedge aclk) prbs_byte_error <= 1'b1;
      @(posedge aclk);
      prbs_byte_error <= 1'b0;
   endtask : errs
endmodule : tbc_phy_model
`default_nettype wire

//--- tb/tbc_regs_asserts.sv
`default_nettype none
module tbc_regs_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic rx_polarity_inverted,
   input wire logic lower_rx_threshold,
   input wire logic [3:0] squelch_level,
   input wire logic link_pulse_tx_off,
   input wire logic jabber_off,
   input wire logic [7:0] generator_gap_quads,
   input wire logic [9:0] generator_gap_bytes,
   input wire logic [10:0] generator_frame_bytes,
   input wire logic phy_status_polarity,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Gap output always four bytes per field step
   AST_GAP_BYTES: assert property (generator_gap_bytes == {generator_gap_quads, 2'b00})
      else $error("gap bytes not four times field");
   AST_RESET_VALUES: assert property ($rose(aresetn) |-> generator_gap_quads == 8'h7D
      && generator_frame_bytes == 11'h5EE && !irq && !phy_status_polarity)
      else $error("wrong values after reset");
   // Config moves only with a write response
   AST_CFG_BY_WRITE: assert property ($changed({lower_rx_threshold, squelch_level,
      link_pulse_tx_off, jabber_off, generator_frame_bytes}) |-> s_axi_bvalid)
      else $error("config output changed without write");
   // Sync chain gives three edges; four samples leave margin
   AST_POL_SET: assert property (rx_polarity_inverted [*4] |=> phy_status_polarity)
      else $error("polarity flag not set");
   AST_POL_HOLD: assert property (phy_status_polarity && !s_axi_arvalid && !s_axi_rvalid
      |=> phy_status_polarity)
      else $error("polarity flag lost without read");
   AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_WRITE_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule : tbc_regs_asserts
bind tbc_regs tbc_regs_asserts i_chk (.*);
`default_nettype wire

//--- tb/tenbase_t_and_builtin_self_test_control_test.sv
`default_nettype none
module tenbase_t_and_builtin_self_test_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic rx_polarity_inverted, prbs_byte_error, error_counter_mode, lower_rx_threshold;
   logic link_pulse_tx_off, jabber_off, phy_status_polarity;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, squelch_level;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [7:0] generator_gap_quads;
   logic [9:0] generator_gap_bytes;
   logic [10:0] generator_frame_bytes;
   logic [15:0] v, cfg;
   int failures, cmp_count, en[3];
   tbc_regs i_dut (.*);
   tbc_phy_model i_phy (.aclk(aclk), .rx_polarity_inverted(rx_polarity_inverted),
      .prbs_byte_error(prbs_byte_error));
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // Readable tenbase bits; polarity is added by the caller
   function automatic logic [31:0] tb_cfg(input logic [15:0] x);
      return {16'h0000, x & 16'h3E81};
   endfunction : tb_cfg
   function automatic logic [7:0] cnt_exp(input logic wrap, input int n);
      return wrap ? 8'(n % 256) : (n > 255 ? 8'hFF : 8'(n));
   endfunction : cnt_exp
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Ready is read in the active region, so it is the pre-edge value
   task wr(input logic [11:0] a, input logic [31:0] x);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) {ad, s_axi_awvalid} <= 2'b10;
         if (!wd && s_axi_wready === 1'b1) {wd, s_axi_wvalid} <= 2'b10;
         #0;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task end_sim;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // Whole run is under a thousand cycles; this limit of 30000 cycles is far beyond
   initial
   begin
      #3000000;
      failures++;
      end_sim;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, error_counter_mode} = '0;
      s_axi_wstrb = 4'hF;
      en = '{5, 300, 260};
      void'($urandom(32'hD7A9F3BA));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h068); chk("tenbase reset", 0, d);
      rd(12'h06C); chk("gap reset", 32'h7D, d);
      rd(12'h070); chk("len reset", 32'h5EE, d);
      // Every documented squelch code 0 to 8 with random neighbours, reserved bits random too
      for (int i = 0; i < 9; i++)
      begin
         v = 16'($urandom);
         v[12:9] = 4'(i);
         wr(12'h068, {16'h0000, v});
         rd(12'h068); chk("tenbase", tb_cfg(v), d);
         chk("tenbase pins", {lower_rx_threshold, squelch_level, link_pulse_tx_off, jabber_off},
            {v[13], v[12:9], v[7], v[0]});
      end
      cfg = v;
      v = 16'($urandom);
      wr(12'h070, {16'h0000, v});
      rd(12'h070); chk("len", v & 16'h07FF, d);
      chk("len pins", v[10:0], generator_frame_bytes);
      s_axi_wstrb <= 4'h1;
      wr(12'h070, 32'h0000_FFFF);
      s_axi_wstrb <= 4'hF;
      rd(12'h070); chk("len lane0", {v[10:8], 8'hFF}, d);
      v[15] = 1'b0;
      wr(12'h06C, {16'h0000, v});
      rd(12'h06C); chk("gap", v[7:0], d);
      chk("gap bytes", {v[7:0], 2'b00}, generator_gap_bytes);
      chk("gap quads", v[7:0], generator_gap_quads);
      // Saturate, then wrap; a stale count would break the wrap case
      for (int k = 0; k < 3; k++)
      begin
         error_counter_mode <= (k == 2);
         wr(12'h06C, {16'h0000, 8'h80, v[7:0]});
         i_phy.errs(en[k]);
         wr(12'h06C, {16'h0000, 8'h80, v[7:0]});
         rd(12'h06C); chk("err count", {cnt_exp(k == 2, en[k]), v[7:0]}, d);
      end
      // Polarity pulse, then released so the flag may clear
      i_phy.pol(1'b1);
      repeat (6) @(posedge aclk);
      i_phy.pol(1'b0);
      repeat (4) @(posedge aclk);
      rd(12'h040); chk("status pol", 32'h1000, d);
      rd(12'h040); chk("status pol kept", 32'h1000, d);
      chk("pol pin", 1, phy_status_polarity);
      rd(12'h068); chk("tenbase pol", tb_cfg(cfg) | 32'h10, d);
      rd(12'h040); chk("status pol cleared", 0, d);
      chk("pol pin cleared", 0, phy_status_polarity);
      rd(12'h0C0); chk("irq status", 3, d);
      chk("irq masked", 0, irq);
      wr(12'h0C4, 2);
      repeat (2) @(posedge aclk);
      chk("irq on", 1, irq);
      wr(12'h0C0, 2);
      repeat (2) @(posedge aclk);
      chk("irq off", 0, irq);
      rd(12'h0C0); chk("irq w1c", 1, d);
      wr(12'h0C0, 1);
      rd(12'h0C0); chk("irq pol w1c", 0, d);
      rd(12'h468); chk("alias rresp", tbc_pkg::RESP_SLVERR, r);
      rd(12'h7FC); chk("bad rresp", tbc_pkg::RESP_SLVERR, r);
      chk("bad rdata", 0, d);
      wr(12'h7FC, $urandom); chk("bad bresp", tbc_pkg::RESP_SLVERR, r);
      // Mid-run reset brings the generator gap back to its default
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h06C); chk("gap after reset", 32'h7D, d);
      rd(12'h070); chk("len after reset", 32'h5EE, d);
      end_sim;
   end
endmodule : tenbase_t_and_builtin_self_test_control_test
`default_nettype wire
